// ==== rtl/irq_prio_defines.svh ====
`ifndef IRQ_PRIO_DEFINES_SVH
`define IRQ_PRIO_DEFINES_SVH

// register indices; byte address is index times four
`define BASIC_PRIO_IDX 10'h0b8
`define EXT_SRC_EN_IDX 10'h0e6
`define EXT_PRIO_IDX 10'h0f6
`define BASIC_EN_IDX 10'h0a8
`define EXT_CFG_IDX 10'h0e4

// reset values
`define BASIC_PRIO_RST 6'h00
`define EXT_SRC_EN_RST 6'h00
`define EXT_PRIO_RST 6'h00
`define BASIC_EN_RST 7'h00
`define EXT_CFG_RST 4'h0

// fixed upper bits of the priority registers and the extended source enable register
`define BASIC_PRIO_TOP 2'h3
`define EXT_SRC_EN_TOP 2'h0
`define EXT_PRIO_TOP 2'h3

// basic enable layout
`define BASIC_EN_GLOBAL_BIT 6

// ext config layout
`define CFG_A_EDGE_BIT 0
`define CFG_B_EDGE_BIT 1
`define CFG_A_POL_BIT 2
`define CFG_B_POL_BIT 3
`define CFG_A_PEND_BIT 4
`define CFG_B_PEND_BIT 5

`endif

// ==== rtl/irq_prio_pkg.sv ====
package irq_prio_pkg;

    typedef struct packed {
        logic cmp_rise;
        logic cmp_fall;
        logic pca;
        logic conv;
        logic win;
        logic smb;
        logic timer2;
        logic uart;
        logic timer1;
        logic timer0;
    } periph_flags_t;

    typedef struct packed {
        logic valid;
        logic high;
        logic [3:0] id;
    } irq_req_t;

    typedef struct packed {
        logic take;
        logic [3:0] id;
    } irq_ack_t;

    typedef enum logic [3:0] {
        SRC_EXT_A = 4'h0,
        SRC_TIMER0 = 4'h1,
        SRC_EXT_B = 4'h2,
        SRC_TIMER1 = 4'h3,
        SRC_UART = 4'h4,
        SRC_TIMER2 = 4'h5,
        SRC_TWOWIRE = 4'h6,
        SRC_WINDOW = 4'h7,
        SRC_CONV = 4'h8,
        SRC_COUNTER_ARRAY = 4'h9,
        SRC_CMP_FALL = 4'ha,
        SRC_CMP_RISE = 4'hb
    } src_id_t;

endpackage

// ==== rtl/irq_prio_ctrl.sv ====
`include "irq_prio_defines.svh"

module irq_prio_ctrl (
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic ext_request_a_i,
    input wire logic ext_request_b_i,
    input wire irq_prio_pkg::periph_flags_t periph_flags_i,
    input wire irq_prio_pkg::irq_ack_t irq_ack_i,
    input wire logic irq_return_i,
    output irq_prio_pkg::irq_req_t irq_req_o
);
    import irq_prio_pkg::*;

    logic rst_meta_r;
    logic rst_n_r;
    logic [5:0] basic_prio_r;
    logic [5:0] ext_en_r;
    logic [5:0] ext_prio_r;
    logic [6:0] basic_en_r;
    logic [3:0] ext_cfg_r;
    logic [1:0] pin_meta_r;
    logic [1:0] pin_sync_r;
    logic [1:0] pin_prev_r;
    logic [1:0] pend_r;
    logic in_low_r;
    logic in_high_r;
    irq_req_t req_r;
    logic pready_r;
    logic [31:0] prdata_r;
    logic pslverr_r;
    logic [1:0] edge_mode;
    logic [1:0] pol;
    logic [1:0] act_cur;
    logic [1:0] act_prev;
    logic [1:0] edge_set;
    logic [11:0] flags;
    logic [11:0] en_vec;
    logic [11:0] prio_vec;
    logic [11:0] live;
    logic [11:0] live_hi;
    logic [11:0] live_lo;
    logic acc;
    logic wr;
    logic hit;
    logic [9:0] idx;
    logic [7:0] rd_val;
    irq_req_t req_nxt;

    function automatic logic [3:0] first_set(input logic [11:0] v);
        logic [3:0] r;
        r = 4'h0;
        for (int i = 11; i >= 0; i--) begin
            if (v[i]) begin
                r = 4'(i);
            end
        end
        return r;
    endfunction

    // reset release
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rst_meta_r <= 1'b0;
            rst_n_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n_r <= rst_meta_r;
        end
    end

    // apb decode
    assign idx = paddr_i[11:2];
    assign acc = psel_i && penable_i;
    assign wr = acc && pready_r && pwrite_i;
    assign hit = (idx == `BASIC_PRIO_IDX) || (idx == `EXT_SRC_EN_IDX) || (idx == `EXT_PRIO_IDX)
        || (idx == `BASIC_EN_IDX) || (idx == `EXT_CFG_IDX);

    always_comb begin
        rd_val = 8'h00;
        if (idx == `BASIC_PRIO_IDX) begin
            rd_val = {`BASIC_PRIO_TOP, basic_prio_r};
        end else if (idx == `EXT_SRC_EN_IDX) begin
            rd_val = {`EXT_SRC_EN_TOP, ext_en_r};
        end else if (idx == `EXT_PRIO_IDX) begin
            rd_val = {`EXT_PRIO_TOP, ext_prio_r};
        end else if (idx == `BASIC_EN_IDX) begin
            rd_val = {basic_en_r[6], 1'b0, basic_en_r[5:0]};
        end else if (idx == `EXT_CFG_IDX) begin
            rd_val = {2'h0, pend_r, ext_cfg_r};
        end
    end

    // one wait state; data captured from flops
    always_ff @(posedge clk_sys_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            pready_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end else begin
            pready_r <= acc && !pready_r;
            if (acc && !pready_r) begin
                prdata_r <= pwrite_i ? 32'h0000_0000 : {24'h00_0000, rd_val};
                pslverr_r <= !hit;
            end
        end
    end

    assign pready_o = pready_r;
    assign prdata_o = prdata_r;
    assign pslverr_o = pready_r && pslverr_r;

    // register writes; upper bits not stored, except bit 7 of basic enable (global gate)
    always_ff @(posedge clk_sys_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            basic_prio_r <= `BASIC_PRIO_RST;
            ext_en_r <= `EXT_SRC_EN_RST;
            ext_prio_r <= `EXT_PRIO_RST;
            basic_en_r <= `BASIC_EN_RST;
            ext_cfg_r <= `EXT_CFG_RST;
        end else if (wr) begin
            if (idx == `BASIC_PRIO_IDX) begin
                basic_prio_r <= pwdata_i[5:0];
            end
            if (idx == `EXT_SRC_EN_IDX) begin
                ext_en_r <= pwdata_i[5:0];
            end
            if (idx == `EXT_PRIO_IDX) begin
                ext_prio_r <= pwdata_i[5:0];
            end
            if (idx == `BASIC_EN_IDX) begin
                basic_en_r <= {pwdata_i[7], pwdata_i[5:0]};
            end
            if (idx == `EXT_CFG_IDX) begin
                ext_cfg_r <= pwdata_i[3:0];
            end
        end
    end

    // pin sampling, input only
    always_ff @(posedge clk_sys_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            pin_meta_r <= 2'h0;
            pin_sync_r <= 2'h0;
            pin_prev_r <= 2'h0;
        end else begin
            pin_meta_r <= {ext_request_b_i, ext_request_a_i};
            pin_sync_r <= pin_meta_r;
            pin_prev_r <= pin_sync_r;
        end
    end

    assign edge_mode = {ext_cfg_r[`CFG_B_EDGE_BIT], ext_cfg_r[`CFG_A_EDGE_BIT]};
    assign pol = {ext_cfg_r[`CFG_B_POL_BIT], ext_cfg_r[`CFG_A_POL_BIT]};
    assign act_cur = pin_sync_r ^ ~pol;
    assign act_prev = pin_prev_r ^ ~pol;
    assign edge_set = act_cur & ~act_prev;

    // pending flags; set beats clear
    always_ff @(posedge clk_sys_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            pend_r <= 2'h0;
        end else begin
            for (int k = 0; k < 2; k++) begin
                if (!edge_mode[k]) begin
                    pend_r[k] <= act_cur[k];
                end else if (edge_set[k]) begin
                    pend_r[k] <= 1'b1;
                end else if (irq_ack_i.take && irq_ack_i.id == (k == 0 ? SRC_EXT_A : SRC_EXT_B)) begin
                    pend_r[k] <= 1'b0;
                end else if (wr && idx == `EXT_CFG_IDX) begin
                    pend_r[k] <= pwdata_i[`CFG_A_PEND_BIT + k];
                end
            end
        end
    end

    assign flags = {periph_flags_i.cmp_rise, periph_flags_i.cmp_fall, periph_flags_i.pca,
        periph_flags_i.conv, periph_flags_i.win, periph_flags_i.smb, periph_flags_i.timer2,
        periph_flags_i.uart, periph_flags_i.timer1, pend_r[1], periph_flags_i.timer0, pend_r[0]};
    assign en_vec = {ext_en_r, basic_en_r[5:0]};
    assign prio_vec = {ext_prio_r, basic_prio_r};
    assign live = flags & en_vec & {12{basic_en_r[`BASIC_EN_GLOBAL_BIT]}};
    assign live_hi = live & prio_vec;
    assign live_lo = live & ~prio_vec;

    always_comb begin
        req_nxt = '0;
        if (!in_high_r && |live_hi) begin
            req_nxt.valid = 1'b1;
            req_nxt.high = 1'b1;
            req_nxt.id = first_set(live_hi);
        end else if (!in_high_r && !in_low_r && |live_lo) begin
            req_nxt.valid = 1'b1;
            req_nxt.id = first_set(live_lo);
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            req_r <= '0;
        end else if (irq_ack_i.take) begin
            req_r <= '0;
        end else begin
            req_r <= req_nxt;
        end
    end

    assign irq_req_o = req_r;

    // in-service levels
    always_ff @(posedge clk_sys_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            in_low_r <= 1'b0;
            in_high_r <= 1'b0;
        end else if (irq_ack_i.take) begin
            if (req_r.high) begin
                in_high_r <= 1'b1;
            end else begin
                in_low_r <= 1'b1;
            end
        end else if (irq_return_i) begin
            if (in_high_r) begin
                in_high_r <= 1'b0;
            end else begin
                in_low_r <= 1'b0;
            end
        end
    end

    // checks
    logic [11:0] en_d_r;
    logic [11:0] prio_d_r;
    always_ff @(posedge clk_sys_i) begin
        en_d_r <= en_vec;
        prio_d_r <= prio_vec;
    end

    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!rst_n_r);

    property p_prio_top;
        pready_o && !pwrite_i && $past(idx) == `BASIC_PRIO_IDX && $past(acc) |-> prdata_o[7:6] == 2'h3;
    endproperty
    a_prio_top: assert property (p_prio_top) else $error("basic priority top bits not 11b");

    property p_en_top;
        pready_o && !pwrite_i && $past(idx) == `EXT_SRC_EN_IDX && $past(acc) |-> prdata_o[7:6] == 2'h0;
    endproperty
    a_en_top: assert property (p_en_top) else $error("extended enable top bits not 00b");

    property p_eprio_top;
        pready_o && !pwrite_i && $past(idx) == `EXT_PRIO_IDX && $past(acc) |-> prdata_o[7:6] == 2'h3;
    endproperty
    a_eprio_top: assert property (p_eprio_top) else $error("extended priority top bits not 11b");

    property p_level_match;
        req_r.valid |-> req_r.high == prio_d_r[req_r.id];
    endproperty
    a_level_match: assert property (p_level_match) else $error("request level differs from priority bit");

    property p_masked;
        req_r.valid |-> en_d_r[req_r.id];
    endproperty
    a_masked: assert property (p_masked) else $error("masked source requested");

    property p_global;
        !$past(basic_en_r[6]) |-> !req_r.valid;
    endproperty
    a_global: assert property (p_global) else $error("request while global gate off");

    property p_no_preempt;
        $past(in_high_r) |-> !req_r.valid;
    endproperty
    a_no_preempt: assert property (p_no_preempt) else $error("high routine preempted");

    property p_edge_clear;
        irq_ack_i.take && irq_ack_i.id == SRC_EXT_A && edge_mode[0] && !edge_set[0] |=> !pend_r[0];
    endproperty
    a_edge_clear: assert property (p_edge_clear) else $error("edge pending not cleared on vector");

    property p_level_follow;
        !edge_mode[1] |=> pend_r[1] == $past(act_cur[1]);
    endproperty
    a_level_follow: assert property (p_level_follow) else $error("level pending does not follow input");

    property p_edge_set;
        edge_mode[0] && edge_set[0] |=> pend_r[0];
    endproperty
    a_edge_set: assert property (p_edge_set) else $error("edge not latched");

    property p_polarity;
        ##2 (pol[0] == $past(pol[0], 2))
            |-> act_cur[0] == (pol[0] ? $past(ext_request_a_i, 2) : !$past(ext_request_a_i, 2));
    endproperty
    a_polarity: assert property (p_polarity) else $error("polarity applied wrongly");

    c_high_req: cover property (req_r.valid && req_r.high);
    c_preempt: cover property (in_low_r && req_r.valid && req_r.high);
    c_edge_ack: cover property (irq_ack_i.take && irq_ack_i.id == SRC_EXT_B && edge_mode[1]);
    c_slverr: cover property (pslverr_o);

endmodule

// ==== verif/cpu_seq_model.sv ====
module cpu_seq_model (
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    input wire irq_prio_pkg::irq_req_t irq_req_i,
    input wire logic take_en_i,
    input wire logic [3:0] delay_i,
    input wire logic ret_i,
    output irq_prio_pkg::irq_ack_t irq_ack_o,
    output logic irq_return_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] cnt_r;

    // vector to the presented source after a programmable wait
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cnt_r <= 4'h0;
            irq_ack_o <= '0;
        end else begin
            irq_ack_o <= '0;
            if (take_en_i && irq_req_i.valid && !irq_ack_o.take) begin
                if (cnt_r >= delay_i) begin
                    irq_ack_o <= '{take: 1'b1, id: irq_req_i.id};
                    cnt_r <= 4'h0;
                end else begin
                    cnt_r <= cnt_r + 4'h1;
                end
            end else begin
                cnt_r <= 4'h0;
            end
        end
    end

    // return from routine on request
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            irq_return_o <= 1'b0;
        end else begin
            irq_return_o <= ret_i;
        end
    end
endmodule

// ==== verif/tb.sv ====
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import irq_prio_pkg::*;
    localparam logic [11:0] A_BP = 12'h2e0;
    localparam logic [11:0] A_EE = 12'h398;
    localparam logic [11:0] A_EP = 12'h3d8;
    localparam logic [11:0] A_BE = 12'h2a0;
    localparam logic [11:0] A_CF = 12'h390;
    logic clk_sys_i;
    logic nrst_i = 1'b0;
    logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, rdy, serr, slverr, irq_ret;
    logic [11:0] pa = 12'h000;
    logic [31:0] pwd = 32'h0, rdat, q;
    logic ext_a = 1'b0, ext_b = 1'b0, en = 1'b0, ret = 1'b0;
    logic [3:0] dly = 4'h0;
    periph_flags_t fl = '0;
    irq_req_t req;
    irq_ack_t ack;
    int err_total = 0;
    int tests_run = 0;

    irq_prio_ctrl uut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .psel_i(psel), .penable_i(pen),
        .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd), .prdata_o(rdat), .pready_o(rdy),
        .pslverr_o(slverr), .ext_request_a_i(ext_a), .ext_request_b_i(ext_b),
        .periph_flags_i(fl), .irq_ack_i(ack), .irq_return_i(irq_ret), .irq_req_o(req));
    cpu_seq_model cpu (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .irq_req_i(req), .take_en_i(en),
        .delay_i(dly), .ret_i(ret), .irq_ack_o(ack), .irq_return_o(irq_ret));

    initial begin
        clk_sys_i = 1'b0;
        forever #25 clk_sys_i = ~clk_sys_i;
    end

    task wt(input int n);
        repeat (n) @(posedge clk_sys_i);
    endtask

    task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        psel <= 1'b1;
        pwr <= w;
        pa <= a;
        pwd <= {24'h0, d};
        @(posedge clk_sys_i);
        pen <= 1'b1;
        do begin
            @(posedge clk_sys_i);
        end while (rdy !== 1'b1);
        q = rdat;
        serr = slverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask

    task chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %0t value %h expected %h", $time, got, exp);
        end
    endtask

    task chk_req(input irq_req_t e);
        tests_run++;
        if (req !== e) begin
            err_total++;
            $display("MISMATCH %0t request %h expected %h", $time, req, e);
        end
    endtask

    task rd(input logic [11:0] a, input logic [7:0] e);
        apb(1'b0, a, 8'h00);
        chk(q[7:0], e);
    endtask

    task pulse_ret;
        ret <= 1'b1;
        wt(1);
        ret <= 1'b0;
        wt(1);
    endtask

    task end_sim;
        $display("comparisons %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        wt(20000);
        err_total++;
        end_sim;
    end

    initial begin
        wt(5);
        nrst_i <= 1'b1;
        wt(3);
        rd(A_BP, 8'hc0);
        rd(A_EE, 8'h00);
        rd(A_EP, 8'hc0);
        apb(1'b1, A_BP, 8'hff);
        rd(A_BP, 8'hff);
        apb(1'b1, A_BP, 8'h00);
        rd(A_BP, 8'hc0);
        apb(1'b1, A_EE, 8'hff);
        rd(A_EE, 8'h3f);
        apb(1'b1, A_EP, 8'h00);
        rd(A_EP, 8'hc0);
        apb(1'b0, 12'h004, 8'h00);
        chk({7'h0, serr}, 8'h01);
        $display("registers test done");
        apb(1'b1, A_BE, 8'h80);
        for (int k = 0; k < 6; k++) begin
            fl <= periph_flags_t'(10'h010 << k);
            apb(1'b1, A_EE, 8'h01 << k);
            apb(1'b1, A_EP, 8'h00);
            wt(3);
            chk_req({1'b1, 1'b0, 4'(6 + k)});
            apb(1'b1, A_EP, 8'h01 << k);
            wt(3);
            chk_req({1'b1, 1'b1, 4'(6 + k)});
            apb(1'b1, A_EE, ~(8'h01 << k));
            wt(3);
            chk_req('0);
        end
        apb(1'b1, A_EE, 8'h3f);
        apb(1'b1, A_BE, 8'h00);
        wt(3);
        chk_req('0);
        $display("mask test done");
        fl <= periph_flags_t'(10'h009);
        apb(1'b1, A_EE, 8'h00);
        apb(1'b1, A_BE, 8'ha2);
        wt(3);
        chk_req({1'b1, 1'b0, 4'h1});
        apb(1'b1, A_BP, 8'h20);
        wt(3);
        chk_req({1'b1, 1'b1, 4'h5});
        apb(1'b1, A_BP, 8'h00);
        fl <= periph_flags_t'(10'h001);
        wt(2);
        dly <= 4'h0;
        en <= 1'b1;
        wt(8);
        en <= 1'b0;
        chk_req('0);
        fl <= periph_flags_t'(10'h009);
        apb(1'b1, A_BP, 8'h20);
        wt(3);
        chk_req({1'b1, 1'b1, 4'h5});
        dly <= 4'h3;
        en <= 1'b1;
        wt(10);
        en <= 1'b0;
        chk_req('0);
        pulse_ret;
        pulse_ret;
        wt(3);
        chk_req({1'b1, 1'b1, 4'h5});
        fl <= '0;
        $display("priority test done");
        apb(1'b1, A_BE, 8'h81);
        apb(1'b1, A_CF, 8'h04);
        ext_a <= 1'b1;
        wt(6);
        chk_req({1'b1, 1'b0, 4'h0});
        rd(A_CF, 8'h34);
        ext_a <= 1'b0;
        wt(6);
        rd(A_CF, 8'h24);
        chk_req('0);
        apb(1'b1, A_CF, 8'h00);
        wt(6);
        rd(A_CF, 8'h30);
        ext_a <= 1'b1;
        wt(6);
        rd(A_CF, 8'h20);
        ext_a <= 1'b0;
        wt(4);
        apb(1'b1, A_CF, 8'h05);
        apb(1'b1, A_CF, 8'h05);
        rd(A_CF, 8'h25);
        ext_a <= 1'b1;
        wt(2);
        ext_a <= 1'b0;
        wt(6);
        rd(A_CF, 8'h35);
        chk_req({1'b1, 1'b0, 4'h0});
        dly <= 4'h2;
        en <= 1'b1;
        wt(8);
        en <= 1'b0;
        rd(A_CF, 8'h25);
        pulse_ret;
        apb(1'b1, A_BE, 8'h84);
        apb(1'b1, A_CF, 8'h08);
        ext_b <= 1'b1;
        wt(6);
        chk_req({1'b1, 1'b0, 4'h2});
        rd(A_CF, 8'h38);
        ext_b <= 1'b0;
        $display("external request test done");
        end_sim;
    end
endmodule
